// *** rtl/alu_core_pkg.sv ***
package alu_core_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLKS_PER_ICYCLE = 4;
	localparam logic [1:0] PHASE_AFTER_TAKE = 2'h0;
	localparam logic [1:0] PHASE_FIRST      = 2'h0;
	localparam logic [1:0] PHASE_LAST       = 2'(CLKS_PER_ICYCLE - 1);

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int              PC_W         = 12;
	localparam int              PM_W         = 16;
	localparam logic [PC_W-1:0] PC_RESET     = 12'h000;
	localparam logic [7:0]      WORK_RESET   = 8'h00;
	localparam logic [7:0]      STATUS_RESET = 8'h00;
	localparam logic [7:0]      TBLH_RESET   = 8'h00;
	localparam logic [7:0]      TBLP_RESET   = 8'h00;
	localparam logic [7:0]      PCL_MEM_ADDR = 8'h06;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_Z      = 0;
	localparam int FLAG_C      = 1;
	localparam int FLAG_HALF   = 2;
	localparam int FLAG_EXCESS = 3;
	localparam int FLAG_PDF    = 4;
	localparam int FLAG_TO     = 5;
	localparam logic [7:0] STATUS_SW_MASK = 8'h0F;

	// ----------------------------------------------------------------
	// Register port offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_WORK   = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_TBLH   = 3'h2;
	localparam logic [2:0] REG_TBLP   = 3'h3;
	localparam logic [2:0] REG_PCL    = 3'h4;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP        = 5'h00,
		OP_MOVE       = 5'h01,
		OP_ADD        = 5'h02,
		OP_ADD_CARRY  = 5'h03,
		OP_SUB        = 5'h04,
		OP_SUB_BORROW = 5'h05,
		OP_DEC_ADJUST = 5'h06,
		OP_AND        = 5'h07,
		OP_OR         = 5'h08,
		OP_XOR        = 5'h09,
		OP_INVERT     = 5'h0A,
		OP_INCR       = 5'h0B,
		OP_DECR       = 5'h0C,
		OP_ROT_RIGHT  = 5'h0D,
		OP_ROT_LEFT   = 5'h0E,
		OP_ROT_RIGHT_C = 5'h0F,
		OP_ROT_LEFT_C = 5'h10,
		OP_BIT_SET    = 5'h11,
		OP_BIT_CLEAR  = 5'h12,
		OP_SKIP_ZERO  = 5'h13,
		OP_SKIP_BIT0  = 5'h14,
		OP_SKIP_BIT1  = 5'h15,
		OP_JUMP       = 5'h16,
		OP_CALL       = 5'h17,
		OP_EXIT       = 5'h18,
		OP_TABLE      = 5'h19,
		OP_WDT_CLEAR  = 5'h1A,
		OP_POWER_DOWN = 5'h1B
	} op_t;

	typedef struct packed {
		op_t             op;
		logic            use_imm;
		logic            to_mem;
		logic [2:0]      bit_sel;
		logic [7:0]      mem_addr;
		logic [7:0]      imm;
		logic [PC_W-1:0] target;
	} instr_t;

	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       half;
		logic       excess;
	} sum_t;

endpackage

// *** rtl/mcu_alu_datapath.sv ***
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
// Contract
// RULE1: Moves: memory-to-work, work-to-memory, immediate-to-work.
// RULE2: Eight-bit arithmetic; carry/borrow beyond 255 or 0.
// RULE3: Increment/decrement by one, memory or work.
// RULE4: Logical results set zero flag when zero.
// RULE5: Rotate one bit; via-carry swaps through carry.
// RULE6: Call saves next address; exit resumes; jump saves nothing.
// RULE7: Skips test byte or bit, skip next instruction.
// RULE8: Bit set/clear touches only the chosen bit.
// RULE9: Table fetch from program memory to memory and high.
// RULE10: Add updates zero, carry, half, excess flags.
// RULE11: Add with carry includes carry; same four flags.
// RULE12: Subtract to work or memory; four flags.
// RULE13: Subtract with borrow uses carry; four flags.
// RULE14: Decimal adjust work into memory; carry only.
// RULE15: Logical ops one cycle; zero flag only.
// RULE16: Invert memory byte to memory or work; zero.
// RULE17: Increment/decrement update only zero flag.
// RULE18: Plain rotates recirculate bit; no flags.
// RULE19: Via-carry rotates change only the carry flag.
// RULE20: Instruction cycle is four clocks; some take two.
// RULE21: Taken skips and program counter writes take two.
// RULE22: Watchdog clear and power down update status flags.
// RULE23: Own operation encoding covers every form.
// RULE24: Subtraction carry set means no borrow.
module mcu_alu_datapath
	import alu_core_pkg::*;
#(
	parameter int STACK_DEPTH = 8
)(
	input  wire logic            clk,
	input  wire logic            rst_b,
	input  wire logic            instr_valid,
	input  wire instr_t          instr,
	output logic                 instr_ready,
	output logic                 instr_done,
	output logic [7:0]           dm_addr,
	input  wire logic [7:0]      dm_rdata,
	output logic [7:0]           dm_wdata,
	output logic                 dm_wr,
	output logic [PC_W-1:0]      pm_addr,
	input  wire logic [PM_W-1:0] pm_rdata,
	output logic [PC_W-1:0]      pc,
	output logic                 wdt_clear,
	output logic                 power_down,
	input  wire logic            wdt_timeout,
	input  wire logic [2:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic [7:0]           reg_rdata
);

	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------
	function automatic sum_t add8(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [8:0] full;
		logic [4:0] low;
		sum_t       s;
		full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		s.res = full[7:0];
		s.c = full[8];
		s.half = low[4];
		s.excess = (a[7] == b[7]) && (full[7] != a[7]);
		return s;
	endfunction

	// Returns the carry in bit 8 and the adjusted byte below it.
	function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic half,
		input logic c);
		logic [8:0] t;
		t = {1'b0, a};
		if ((a[3:0] > 4'h9) || half)
		begin
			t = t + 9'h006;
		end
		if ((t[7:4] > 4'h9) || c || t[8])
		begin
			t = t + 9'h060;
			t[8] = 1'b1;
		end
		t[8] = t[8] | c;
		return t;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_EXTRA = 3'b100
	} state_t;

	state_t          state_r;
	state_t          state_nxt;
	logic [1:0]      phase_r;
	logic [1:0]      phase_nxt;
	instr_t          cur_r;
	instr_t          cur_nxt;
	logic [7:0]      work_r;
	logic [7:0]      work_nxt;
	logic [7:0]      status_r;
	logic [7:0]      status_nxt;
	logic [7:0]      tblh_r;
	logic [7:0]      tblh_nxt;
	logic [7:0]      tblp_r;
	logic [7:0]      tblp_nxt;
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pc_nxt;
	logic [SP_W-1:0] sp_r;
	logic [SP_W-1:0] sp_nxt;
	logic [PC_W-1:0] stack_r [STACK_DEPTH];
	logic [PC_W-1:0] stack_nxt [STACK_DEPTH];
	logic [7:0]      dm_addr_r;
	logic [7:0]      dm_addr_nxt;
	logic [7:0]      dm_wdata_r;
	logic [7:0]      dm_wdata_nxt;
	logic            dm_wr_r;
	logic            dm_wr_nxt;
	logic            wdt_clear_r;
	logic            wdt_clear_nxt;
	logic            power_down_r;
	logic            power_down_nxt;
	logic [7:0]      rdata_r;
	logic [7:0]      rdata_nxt;

	logic            commit;
	logic            extra;
	logic            finish;
	logic [7:0]      opnd;
	logic [7:0]      res;
	logic [7:0]      mask;
	logic            writes;
	logic            dest_mem;
	logic            skip;
	logic            cin;
	logic [PC_W-1:0] pc_inc;
	logic [8:0]      bcd;
	sum_t            s;

	assign commit = (state_r == ST_EXEC) && (phase_r == PHASE_LAST);
	assign finish = (commit && !extra) || ((state_r == ST_EXTRA) && (phase_r == PHASE_LAST));
	assign instr_ready = (state_r == ST_IDLE) || finish;
	assign instr_done = finish;

	assign dm_addr = dm_addr_r;
	assign dm_wdata = dm_wdata_r;
	assign dm_wr = dm_wr_r;
	assign pm_addr = {pc_r[PC_W-1:8], tblp_r};
	assign pc = pc_r;
	assign wdt_clear = wdt_clear_r;
	assign power_down = power_down_r;
	assign reg_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		phase_nxt = phase_r + 2'h1;
		cur_nxt = cur_r;
		dm_addr_nxt = dm_addr_r;
		unique case (state_r)
			ST_IDLE:
			begin
				phase_nxt = PHASE_FIRST;
			end
			ST_EXEC:
			begin
				if (commit && extra)
				begin
					state_nxt = ST_EXTRA; // RULE20 RULE21
				end
				else if (commit)
				begin
					state_nxt = ST_IDLE;
				end
			end
			ST_EXTRA:
			begin
				if (phase_r == PHASE_LAST)
				begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
		if (instr_ready && instr_valid)
		begin
			state_nxt = ST_EXEC;
			phase_nxt = PHASE_AFTER_TAKE; // RULE20
			cur_nxt = instr;
			dm_addr_nxt = instr.mem_addr;
		end
	end

	// ----------------------------------------------------------------
	// Execution
	// ----------------------------------------------------------------
	always_comb
	begin
		opnd = cur_r.use_imm ? cur_r.imm : dm_rdata;
		cin = status_r[FLAG_C];
		mask = 8'h01 << cur_r.bit_sel;
		pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
		s = add8(work_r, opnd, 1'b0);
		bcd = bcd_fix(work_r, status_r[FLAG_HALF], cin);
		res = opnd;
		writes = 1'b0;
		dest_mem = cur_r.to_mem;
		skip = 1'b0;
		extra = 1'b0;
		work_nxt = work_r;
		status_nxt = status_r;
		tblh_nxt = tblh_r;
		tblp_nxt = tblp_r;
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		stack_nxt = stack_r;
		dm_wdata_nxt = dm_wdata_r;
		dm_wr_nxt = 1'b0;
		wdt_clear_nxt = 1'b0;
		power_down_nxt = 1'b0;
		rdata_nxt = 8'h00;

		if (reg_rd)
		begin
			unique case (reg_addr)
				REG_WORK:   rdata_nxt = work_r;
				REG_STATUS: rdata_nxt = status_r;
				REG_TBLH:   rdata_nxt = tblh_r;
				REG_TBLP:   rdata_nxt = tblp_r;
				REG_PCL:    rdata_nxt = pc_r[7:0];
				default:    rdata_nxt = 8'h00;
			endcase
		end
		if (reg_wr)
		begin
			unique case (reg_addr)
				REG_WORK:   work_nxt = reg_wdata;
				REG_STATUS: status_nxt = (status_r & ~STATUS_SW_MASK)
					| (reg_wdata & STATUS_SW_MASK);
				REG_TBLP:   tblp_nxt = reg_wdata;
				default:    tblp_nxt = tblp_r;
			endcase
		end

		if (commit)
		begin
			pc_nxt = pc_inc;
			unique case (cur_r.op) // RULE23
				OP_NOP:
				begin
					writes = 1'b0;
				end
				OP_MOVE:
				begin
					res = cur_r.to_mem ? work_r : opnd; // RULE1
					dest_mem = cur_r.to_mem && !cur_r.use_imm;
					writes = 1'b1;
				end
				OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW:
				begin
					unique case (cur_r.op)
						OP_ADD:        s = add8(work_r, opnd, 1'b0); // RULE10
						OP_ADD_CARRY:  s = add8(work_r, opnd, cin); // RULE11
						OP_SUB:        s = add8(work_r, ~opnd, 1'b1); // RULE12 RULE24
						default:       s = add8(work_r, ~opnd, cin); // RULE13
					endcase
					res = s.res;
					writes = 1'b1;
					status_nxt[FLAG_C] = s.c; // RULE2
					status_nxt[FLAG_HALF] = s.half;
					status_nxt[FLAG_EXCESS] = s.excess;
					status_nxt[FLAG_Z] = (s.res == 8'h00);
				end
				OP_DEC_ADJUST:
				begin
					res = bcd[7:0];
					dest_mem = 1'b1; // RULE14
					writes = 1'b1;
					status_nxt[FLAG_C] = bcd[8];
				end
				OP_AND, OP_OR, OP_XOR, OP_INVERT, OP_INCR, OP_DECR:
				begin
					unique case (cur_r.op)
						OP_AND:    res = work_r & opnd; // RULE15
						OP_OR:     res = work_r | opnd;
						OP_XOR:    res = work_r ^ opnd;
						OP_INVERT: res = ~dm_rdata; // RULE16
						OP_INCR:   res = dm_rdata + 8'h01; // RULE3
						default:   res = dm_rdata - 8'h01;
					endcase
					writes = 1'b1;
					status_nxt[FLAG_Z] = (res == 8'h00); // RULE4 RULE17
				end
				OP_ROT_RIGHT:
				begin
					res = {dm_rdata[0], dm_rdata[7:1]}; // RULE18
					writes = 1'b1;
				end
				OP_ROT_LEFT:
				begin
					res = {dm_rdata[6:0], dm_rdata[7]}; // RULE18
					writes = 1'b1;
				end
				OP_ROT_RIGHT_C:
				begin
					res = {cin, dm_rdata[7:1]}; // RULE5
					status_nxt[FLAG_C] = dm_rdata[0]; // RULE19
					writes = 1'b1;
				end
				OP_ROT_LEFT_C:
				begin
					res = {dm_rdata[6:0], cin}; // RULE5
					status_nxt[FLAG_C] = dm_rdata[7]; // RULE19
					writes = 1'b1;
				end
				OP_BIT_SET, OP_BIT_CLEAR:
				begin
					res = (cur_r.op == OP_BIT_SET) ? (dm_rdata | mask)
						: (dm_rdata & ~mask); // RULE8
					dest_mem = 1'b1;
					writes = 1'b1;
				end
				OP_SKIP_ZERO:
				begin
					skip = (dm_rdata == 8'h00); // RULE7
				end
				OP_SKIP_BIT0:
				begin
					skip = ((dm_rdata & mask) == 8'h00); // RULE7
				end
				OP_SKIP_BIT1:
				begin
					skip = ((dm_rdata & mask) != 8'h00); // RULE7
				end
				OP_JUMP:
				begin
					pc_nxt = cur_r.target; // RULE6
					extra = 1'b1;
				end
				OP_CALL:
				begin
					stack_nxt[sp_r] = pc_inc; // RULE6
					sp_nxt = (int'(sp_r) == STACK_DEPTH - 1) ? '0 : sp_r + 1'b1;
					pc_nxt = cur_r.target;
					extra = 1'b1;
				end
				OP_EXIT:
				begin
					sp_nxt = (sp_r == '0) ? SP_W'(STACK_DEPTH - 1) : sp_r - 1'b1;
					pc_nxt = stack_r[sp_nxt]; // RULE6
					extra = 1'b1;
				end
				OP_TABLE:
				begin
					res = pm_rdata[7:0]; // RULE9
					tblh_nxt = pm_rdata[PM_W-1:8];
					dest_mem = 1'b1;
					writes = 1'b1;
					extra = 1'b1;
				end
				OP_WDT_CLEAR:
				begin
					status_nxt[FLAG_TO] = 1'b0; // RULE22
					status_nxt[FLAG_PDF] = 1'b0;
					wdt_clear_nxt = 1'b1;
				end
				OP_POWER_DOWN:
				begin
					status_nxt[FLAG_TO] = 1'b0; // RULE22
					status_nxt[FLAG_PDF] = 1'b1;
					power_down_nxt = 1'b1;
				end
				default:
				begin
					writes = 1'b0;
				end
			endcase

			if (writes && dest_mem && (cur_r.mem_addr == PCL_MEM_ADDR))
			begin
				pc_nxt = {pc_inc[PC_W-1:8], res}; // RULE21
				extra = 1'b1;
			end
			else if (writes && dest_mem)
			begin
				dm_wr_nxt = 1'b1;
				dm_wdata_nxt = res;
			end
			else if (writes)
			begin
				work_nxt = res;
			end
			if (skip)
			begin
				pc_nxt = pc_inc + {{(PC_W-1){1'b0}}, 1'b1}; // RULE21
				extra = 1'b1;
			end
		end

		if (wdt_timeout)
		begin
			status_nxt[FLAG_TO] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= ST_IDLE;
			phase_r <= PHASE_FIRST;
			cur_r <= '0;
			work_r <= WORK_RESET;
			status_r <= STATUS_RESET;
			tblh_r <= TBLH_RESET;
			tblp_r <= TBLP_RESET;
			pc_r <= PC_RESET;
			sp_r <= '0;
			stack_r <= '{default: PC_RESET};
			dm_addr_r <= 8'h00;
			dm_wdata_r <= 8'h00;
			dm_wr_r <= 1'b0;
			wdt_clear_r <= 1'b0;
			power_down_r <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			cur_r <= cur_nxt;
			work_r <= work_nxt;
			status_r <= status_nxt;
			tblh_r <= tblh_nxt;
			tblp_r <= tblp_nxt;
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			stack_r <= stack_nxt;
			dm_addr_r <= dm_addr_nxt;
			dm_wdata_r <= dm_wdata_nxt;
			dm_wr_r <= dm_wr_nxt;
			wdt_clear_r <= wdt_clear_nxt;
			power_down_r <= power_down_nxt;
			rdata_r <= rdata_nxt;
		end
	end

endmodule

// *** test/mcu_alu_datapath_asserts.sv ***
`timescale 1ns/1ns
module mcu_alu_datapath_asserts
	import alu_core_pkg::*;
(
	input wire logic            clk,
	input wire logic            rst_b,
	input wire logic            instr_valid,
	input wire instr_t          instr,
	input wire logic            instr_ready,
	input wire logic            instr_done,
	input wire logic            dm_wr,
	input wire logic [PC_W-1:0] pc,
	input wire logic            wdt_clear,
	input wire logic            power_down
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence s_take;
		instr_valid && instr_ready;
	endsequence
	sequence s_one;
		!instr_done [*3] ##1 instr_done;
	endsequence
	sequence s_two;
		!instr_done [*7] ##1 instr_done;
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_take_done;
		s_take |=> s_one or s_two;
	endproperty
	a_take_done: assert property (p_take_done) else $error("done not after one or two cycles");
	property p_busy;
		s_take |=> !instr_ready [*3];
	endproperty
	a_busy: assert property (p_busy) else $error("ready during execution");
	property p_done_ready;
		instr_done |-> instr_ready ##1 !instr_done;
	endproperty
	a_done_ready: assert property (p_done_ready) else $error("done without ready");
	property p_wr_pulse;
		dm_wr |=> !dm_wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("memory write longer than one clock");
	property p_wr_after;
		dm_wr |-> $past(instr_valid && instr_ready, 5);
	endproperty
	a_wr_after: assert property (p_wr_after) else $error("memory write not five clocks after take");
	property p_wdt;
		instr_valid && instr_ready && instr.op == OP_WDT_CLEAR |-> ##5 wdt_clear;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clear pulse missing");
	property p_pdn;
		instr_valid && instr_ready && instr.op == OP_POWER_DOWN |-> ##5 power_down;
	endproperty
	a_pdn: assert property (p_pdn) else $error("power down pulse missing");
	property p_pc;
		$changed(pc) |-> $past(instr_valid && instr_ready, 5);
	endproperty
	a_pc: assert property (p_pc) else $error("program counter moved outside a commit");
endmodule

// *** test/mcu_alu_datapath_bench.sv ***
`timescale 1ns/1ns
module mcu_alu_datapath_bench;
	import alu_core_pkg::*;
	logic            clk, rst_b, instr_valid, instr_ready, instr_done, dm_wr;
	logic            wdt_clear, power_down, wdt_timeout, reg_wr, reg_rd, wr_seen;
	instr_t          instr;
	logic [7:0]      dm_addr, dm_rdata, dm_wdata, reg_wdata, reg_rdata, wd, rv;
	logic [2:0]      reg_addr;
	logic [PC_W-1:0] pm_addr, pc, p;
	logic [PM_W-1:0] pm_rdata;
	logic [15:0]     ncyc;
	int              miscompares, cmp_count, cyc;

	mcu_alu_datapath i_mcu_alu_datapath (
		.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .instr_done(instr_done), .dm_addr(dm_addr),
		.dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_wr(dm_wr), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .pc(pc), .wdt_clear(wdt_clear), .power_down(power_down),
		.wdt_timeout(wdt_timeout), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		@(negedge clk);
		rv = reg_rdata;
	endtask

	// Issues one instruction and counts clocks from the take edge to done.
	task automatic run(input op_t op, input logic u, input logic t, input logic [7:0] v,
		input logic [7:0] m, input logic [PC_W-1:0] tg = 12'h000,
		input logic [7:0] ma = 8'h3C);
		@(posedge clk);
		instr       <= '{op:op, use_imm:u, to_mem:t, bit_sel:v[2:0], mem_addr:ma,
			imm:v, target:tg};
		dm_rdata    <= m;
		instr_valid <= 1'h1;
		@(posedge clk);
		instr_valid <= 1'h0;
		wd      = 'x;
		wr_seen = 1'h0;
		for (ncyc = 16'h1; ncyc < 16'hC; ncyc++)
		begin
			@(negedge clk);
			if (dm_wr === 1'h1)
			begin
				wd      = dm_wdata;
				wr_seen = 1'h1;
			end
			if (instr_done === 1'h1)
				break;
		end
		@(negedge clk);
		if (dm_wr === 1'h1)
		begin
			wd      = dm_wdata;
			wr_seen = 1'h1;
		end
	endtask

	// Presets work and status, runs a one-cycle operation, checks result and flags.
	task automatic opchk(input op_t op, input logic u, input logic t, input logic [7:0] w,
		input logic [7:0] s, input logic [7:0] v, input logic [7:0] m,
		input logic [7:0] er, input logic [7:0] es);
		wr(REG_WORK, w);
		wr(REG_STATUS, s);
		run(op, u, t, v, m);
		chk(ncyc, 16'h4);
		chk(dm_addr, 8'h3C);
		chk(wr_seen, t);
		if (t)
			chk(wd, er);
		else
		begin
			rd(REG_WORK);
			chk(rv, er);
		end
		rd(REG_STATUS);
		chk(rv & STATUS_SW_MASK, es);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_move;
		opchk(OP_MOVE, 1'h1, 1'h0, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h5A, 8'h00);
		opchk(OP_MOVE, 1'h0, 1'h0, 8'h00, 8'h0F, 8'h00, 8'hC3, 8'hC3, 8'h0F);
		opchk(OP_MOVE, 1'h0, 1'h1, 8'h7E, 8'h0F, 8'h00, 8'h00, 8'h7E, 8'h0F);
	endtask

	task automatic t_arith;
		opchk(OP_ADD, 1'h1, 1'h0, 8'hF0, 8'h00, 8'h20, 8'h00, 8'h10, 8'h02);
		opchk(OP_ADD_CARRY, 1'h0, 1'h0, 8'h10, 8'h02, 8'h00, 8'hEF, 8'h00, 8'h07);
		opchk(OP_ADD, 1'h0, 1'h1, 8'h7F, 8'h00, 8'h00, 8'h01, 8'h80, 8'h0C);
		opchk(OP_SUB, 1'h1, 1'h0, 8'h10, 8'h00, 8'h20, 8'h00, 8'hF0, 8'h04);
		opchk(OP_SUB_BORROW, 1'h0, 1'h0, 8'hF0, 8'h00, 8'h00, 8'h0F, 8'hE0, 8'h02);
		opchk(OP_SUB, 1'h0, 1'h1, 8'h05, 8'h02, 8'h00, 8'h05, 8'h00, 8'h07);
		opchk(OP_DEC_ADJUST, 1'h0, 1'h1, 8'h3C, 8'h0D, 8'h00, 8'h00, 8'h42, 8'h0D);
		opchk(OP_DEC_ADJUST, 1'h0, 1'h1, 8'h9A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02);
		opchk(OP_INCR, 1'h0, 1'h0, 8'h00, 8'h02, 8'h00, 8'hFF, 8'h00, 8'h03);
		opchk(OP_DECR, 1'h0, 1'h1, 8'h00, 8'h0C, 8'h00, 8'h00, 8'hFF, 8'h0C);
	endtask

	task automatic t_logic;
		opchk(OP_AND, 1'h1, 1'h0, 8'hAA, 8'h02, 8'h55, 8'h00, 8'h00, 8'h03);
		opchk(OP_OR, 1'h1, 1'h0, 8'hAA, 8'h03, 8'h55, 8'h00, 8'hFF, 8'h02);
		opchk(OP_XOR, 1'h0, 1'h0, 8'hAA, 8'h02, 8'h00, 8'hFF, 8'h55, 8'h02);
		opchk(OP_AND, 1'h0, 1'h1, 8'h0F, 8'h02, 8'h00, 8'hF0, 8'h00, 8'h03);
		opchk(OP_INVERT, 1'h0, 1'h0, 8'h00, 8'h02, 8'h00, 8'hFF, 8'h00, 8'h03);
		opchk(OP_INVERT, 1'h0, 1'h1, 8'h00, 8'h03, 8'h00, 8'h0F, 8'hF0, 8'h02);
	endtask

	task automatic t_rotate_bits;
		opchk(OP_ROT_RIGHT, 1'h0, 1'h0, 8'h00, 8'h0F, 8'h00, 8'h81, 8'hC0, 8'h0F);
		opchk(OP_ROT_LEFT, 1'h0, 1'h1, 8'h00, 8'h00, 8'h00, 8'h81, 8'h03, 8'h00);
		opchk(OP_ROT_RIGHT_C, 1'h0, 1'h0, 8'h00, 8'h00, 8'h00, 8'h81, 8'h40, 8'h02);
		opchk(OP_ROT_LEFT_C, 1'h0, 1'h1, 8'h00, 8'h0F, 8'h00, 8'h01, 8'h03, 8'h0D);
		opchk(OP_ROT_RIGHT_C, 1'h0, 1'h0, 8'h00, 8'h0E, 8'h00, 8'h02, 8'h81, 8'h0C);
		opchk(OP_BIT_SET, 1'h0, 1'h1, 8'h00, 8'h05, 8'h07, 8'h00, 8'h80, 8'h05);
		opchk(OP_BIT_CLEAR, 1'h0, 1'h1, 8'h00, 8'h05, 8'h00, 8'hFF, 8'hFE, 8'h05);
	endtask

	task automatic t_flow;
		run(OP_JUMP, 1'h0, 1'h0, 8'h00, 8'h00, 12'h123);
		chk(pc, 12'h123);
		chk(ncyc, 16'h8);
		run(OP_CALL, 1'h0, 1'h0, 8'h00, 8'h00, 12'h200);
		chk(pc, 12'h200);
		run(OP_EXIT, 1'h0, 1'h0, 8'h00, 8'h00);
		chk(pc, 12'h124);
		chk(ncyc, 16'h8);
		p = pc;
		run(OP_SKIP_ZERO, 1'h0, 1'h0, 8'h00, 8'h00);
		chk(pc, p + 12'h002);
		chk(ncyc, 16'h8);
		run(OP_SKIP_ZERO, 1'h0, 1'h0, 8'h00, 8'h01);
		chk(pc, p + 12'h003);
		chk(ncyc, 16'h4);
		run(OP_SKIP_BIT0, 1'h0, 1'h0, 8'h00, 8'hFE);
		chk(pc, p + 12'h005);
		run(OP_SKIP_BIT1, 1'h0, 1'h0, 8'h00, 8'hFE);
		chk(pc, p + 12'h006);
		wr(REG_WORK, 8'h40);
		run(OP_MOVE, 1'h0, 1'h1, 8'h00, 8'h00, 12'h000, PCL_MEM_ADDR);
		chk(pc, 12'h140);
		chk(ncyc, 16'h8);
		chk(wr_seen, 1'h0);
	endtask

	task automatic t_table_status;
		wr(REG_TBLP, 8'h45);
		pm_rdata <= 16'hBEEF;
		@(negedge clk);
		chk(pm_addr[7:0], 8'h45);
		run(OP_TABLE, 1'h0, 1'h0, 8'h00, 8'h00);
		chk(wd, 8'hEF);
		chk(ncyc, 16'h8);
		rd(REG_TBLH);
		chk(rv, 8'hBE);
		@(posedge clk);
		wdt_timeout <= 1'h1;
		@(posedge clk);
		wdt_timeout <= 1'h0;
		rd(REG_STATUS);
		chk(rv[5:4], 2'h2);
		run(OP_POWER_DOWN, 1'h0, 1'h0, 8'h00, 8'h00);
		rd(REG_STATUS);
		chk(rv[5:4], 2'h1);
		run(OP_WDT_CLEAR, 1'h0, 1'h0, 8'h00, 8'h00);
		rd(REG_STATUS);
		chk(rv[5:4], 2'h0);
	endtask

	// ----------------------------------------------------------------
	// Clock, reset, timeout and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			miscompares++;
			final_report();
		end
	end

	initial
	begin
		rst_b       = 1'h0;
		instr_valid = 1'h0;
		instr       = '0;
		dm_rdata    = 8'h00;
		pm_rdata    = 16'h0000;
		wdt_timeout = 1'h0;
		reg_addr    = 3'h0;
		reg_wdata   = 8'h00;
		reg_wr      = 1'h0;
		reg_rd      = 1'h0;
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		t_move();
		t_arith();
		t_logic();
		t_rotate_bits();
		t_flow();
		t_table_status();
		final_report();
	end
endmodule

bind mcu_alu_datapath mcu_alu_datapath_asserts i_mcu_alu_datapath_asserts (
	.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
	.instr_ready(instr_ready), .instr_done(instr_done), .dm_wr(dm_wr), .pc(pc),
	.wdt_clear(wdt_clear), .power_down(power_down)
);
